// [apf_regs.sv]
// Purpose: Register bank and pixel steering for the second custom mode
// Assumes: Quadlet requests come from the serial-bus link layer on clk
// Notes: One request per cycle at most; answer follows one edge later
`timescale 1ns/1ns
`default_nettype none
`include "apf_consts.svh"

module apf_regs
  import apf_pkg::*;
#(
  parameter logic [15:0] MAX_WIDTH = `APF_MAX_WIDTH,
  parameter logic [15:0] MAX_HEIGHT = `APF_MAX_HEIGHT,
  parameter logic [15:0] COL_STEP = `APF_COL_STEP,
  parameter logic [15:0] ROW_STEP = `APF_ROW_STEP
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Quadlet request from link layer
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [47:0] req_addr,
  input wire logic [31:0] req_wdata,
  // Quadlet answer to link layer
  output logic resp_valid,
  output logic resp_err,
  output logic [31:0] resp_rdata,
  // Area of interest and coding to the imaging core
  output logic [15:0] aoi_left,
  output logic [15:0] aoi_top,
  output logic [15:0] aoi_width,
  output logic [15:0] aoi_height,
  output logic [7:0] pixel_format_code,
  // Sensor pixels in, formatted pixels out
  input wire logic [7:0] sensor_pixel,
  input wire logic sensor_valid,
  output logic [7:0] pix_data,
  output logic pix_valid
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Places the field at bit 0 in the upper half of the quadlet
  function automatic logic [31:0] quad(input apf_half_t f0,
                                       input apf_half_t f16);
    quad = {f0, f16};
  endfunction

  function automatic logic sel(input logic [47:0] ofs,
                               input logic [11:0] want);
    sel = (ofs == {36'h0_0000_0000, want});
  endfunction

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // offset is address minus base
  wire [47:0] req_ofs = req_addr - `APF_BASE_ADDR;
  wire in_range = (req_ofs <= {36'h0_0000_0000, `APF_OFS_LAST});
  wire aligned = (req_ofs[1:0] == 2'b00);
  wire hit = in_range && aligned;
  wire sel_max = sel(req_ofs, `APF_OFS_MAX_SIZE);
  wire sel_step = sel(req_ofs, `APF_OFS_STEP);
  wire sel_pos = sel(req_ofs, `APF_OFS_POSITION);
  wire sel_size = sel(req_ofs, `APF_OFS_SIZE);
  wire sel_code = sel(req_ofs, `APF_OFS_CODE_SEL);
  wire sel_sup = sel(req_ofs, `APF_OFS_CODE_SUP);
  wire do_access = ce && req_valid;
  wire wr_pos = do_access && req_write && sel_pos;
  wire wr_size = do_access && req_write && sel_size;
  wire wr_code = do_access && req_write && sel_code;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // max size word
  wire [31:0] max_word = quad(MAX_WIDTH, MAX_HEIGHT);
  wire [31:0] step_word = quad(COL_STEP, ROW_STEP);
  wire [31:0] pos_word = quad(aoi_left, aoi_top);
  wire [31:0] size_word = quad(aoi_width, aoi_height);
  wire [31:0] code_word = {pixel_format_code, 24'h00_0000};
  wire [31:0] sup_word = `APF_CODE_SUPPORT;
  wire [31:0] read_mux =
    sel_max ? max_word :
    sel_step ? step_word :
    sel_pos ? pos_word :
    sel_size ? size_word :
    sel_code ? code_word :
    sel_sup ? sup_word : `APF_ZERO_WORD;

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  // position fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aoi_left <= `APF_POS_RESET;
      aoi_top <= `APF_POS_RESET;
    end else if (wr_pos) begin
      aoi_left <= req_wdata[`APF_HI_MSB:`APF_HI_LSB];
      aoi_top <= req_wdata[`APF_LO_MSB:`APF_LO_LSB];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aoi_width <= `APF_MAX_WIDTH;
      aoi_height <= `APF_MAX_HEIGHT;
    end else if (wr_size) begin
      aoi_width <= req_wdata[`APF_HI_MSB:`APF_HI_LSB];
      aoi_height <= req_wdata[`APF_LO_MSB:`APF_LO_LSB];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pixel_format_code <= `APF_CODE_RESET;
    end else if (wr_code) begin
      pixel_format_code <= req_wdata[`APF_CODE_MSB:`APF_CODE_LSB];
    end
  end

  // ****************************************************************
  // Answer
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_err <= 1'b0;
      resp_rdata <= `APF_ZERO_WORD;
    end else if (ce) begin
      resp_valid <= req_valid;
      resp_err <= req_valid && !hit;
      if (req_valid) begin
        resp_rdata <= req_write ? `APF_ZERO_WORD : read_mux;
      end
    end
  end

  // ****************************************************************
  // Pixel stage
  // ****************************************************************
  apf_pixel_path u_pixel_path (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pixel_format_code(pixel_format_code),
    .sensor_pixel(sensor_pixel),
    .sensor_valid(sensor_valid),
    .pix_data(pix_data),
    .pix_valid(pix_valid)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  wire rd_req = do_access && !req_write;

  property p_base_err;
    @(posedge clk) disable iff (rst)
    (do_access && !hit) |=> (resp_valid && resp_err);
  endproperty
  a_base_err: assert property (p_base_err)
    else $error("bad address ok");

  property p_max_read;
    @(posedge clk) disable iff (rst)
    (rd_req && sel_max) |=> (resp_rdata[31:16] == MAX_WIDTH &&
                             resp_rdata[15:0] == MAX_HEIGHT);
  endproperty
  a_max_read: assert property (p_max_read)
    else $error("max size wrong");

  property p_col_step;
    @(posedge clk) disable iff (rst)
    (rd_req && sel_step) |=> (resp_rdata[31:16] == COL_STEP);
  endproperty
  a_col_step: assert property (p_col_step)
    else $error("col step wrong");

  property p_row_step;
    @(posedge clk) disable iff (rst)
    (rd_req && sel_step) |=> (resp_rdata[15:0] == ROW_STEP);
  endproperty
  a_row_step: assert property (p_row_step)
    else $error("row step wrong");

  property p_pos_write;
    @(posedge clk) disable iff (rst)
    wr_pos |=> (aoi_left == $past(req_wdata[31:16]) &&
                aoi_top == $past(req_wdata[15:0]));
  endproperty
  a_pos_write: assert property (p_pos_write)
    else $error("pos not stored");

  property p_size_hold;
    @(posedge clk) disable iff (rst)
    (!wr_size) |=> $stable(aoi_width) && $stable(aoi_height);
  endproperty
  a_size_hold: assert property (p_size_hold)
    else $error("size changed");

  property p_code_read;
    @(posedge clk) disable iff (rst)
    (rd_req && sel_code) ##1 (!wr_code)
      |-> (resp_rdata[23:0] == 24'h00_0000 &&
           resp_rdata[31:24] == pixel_format_code);
  endproperty
  a_code_read: assert property (p_code_read)
    else $error("code word bad");

  property p_sup_read;
    @(posedge clk) disable iff (rst)
    (rd_req && sel_sup) |=> (resp_rdata == `APF_CODE_SUPPORT);
  endproperty
  a_sup_read: assert property (p_sup_read)
    else $error("support bad");

  property p_ro_write;
    @(posedge clk) disable iff (rst)
    (do_access && req_write && (sel_max || sel_step || sel_sup))
      |=> $stable(aoi_left) && $stable(pixel_format_code);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("ro write acted");

endmodule
`default_nettype wire

// [apf_consts.svh]
// Purpose: Named constants for the custom-format register bank
// Assumes: Quadlet registers, bit 0 of a field list is the quadlet MSB
// Notes: Included by the register bank and the pixel stage; the package does not include it
`ifndef APF_CONSTS_SVH
`define APF_CONSTS_SVH

// ****************************************************************
// Addressing
// ****************************************************************
`define APF_BASE_ADDR 48'hffff_f1f0_0100
`define APF_OFS_MAX_SIZE 12'h000
`define APF_OFS_STEP 12'h004
`define APF_OFS_POSITION 12'h008
`define APF_OFS_SIZE 12'h00c
`define APF_OFS_CODE_SEL 12'h010
`define APF_OFS_CODE_SUP 12'h014
`define APF_OFS_LAST 12'h014

// ****************************************************************
// Field positions (quadlet bit 0 = vector bit 31)
// ****************************************************************
`define APF_HI_MSB 31
`define APF_HI_LSB 16
`define APF_LO_MSB 15
`define APF_LO_LSB 0
`define APF_CODE_MSB 31
`define APF_CODE_LSB 24

// ****************************************************************
// Values and reset values
// ****************************************************************
`define APF_MAX_WIDTH 16'h056c
`define APF_MAX_HEIGHT 16'h040e
`define APF_COL_STEP 16'h0002
`define APF_ROW_STEP 16'h0002
`define APF_POS_RESET 16'h0000
`define APF_CODE_RESET 8'h00
`define APF_CODE_SUPPORT 32'h8000_0000
`define APF_ZERO_WORD 32'h0000_0000

`endif

// [apf_pkg.sv]
// Purpose: Types for the custom-format register bank
// Assumes: Constants come from apf_consts.svh
// Notes: Holds pixel coding codes and the half-quadlet field type
package apf_pkg;

  typedef enum logic [7:0] {
    APF_CODE_MONO8 = 8'h00,
    APF_CODE_YUV411 = 8'h01,
    APF_CODE_YUV422 = 8'h02,
    APF_CODE_YUV444 = 8'h03,
    APF_CODE_RGB8 = 8'h04,
    APF_CODE_MONO16 = 8'h05,
    APF_CODE_RGB16 = 8'h06,
    APF_CODE_SMONO16 = 8'h07,
    APF_CODE_SRGB16 = 8'h08,
    APF_CODE_RAW8 = 8'h09,
    APF_CODE_RAW16 = 8'h0a
  } apf_code_e;

  typedef logic [15:0] apf_half_t;

endpackage

// [apf_pixel_path.sv]
// Purpose: Pixel output stage steered by the selected pixel coding
// Assumes: Sensor pixels arrive on the same clock
// Notes: Only the Mono8 coding (code 0) is supported; others emit nothing
`timescale 1ns/1ns
`default_nettype none
`include "apf_consts.svh"

module apf_pixel_path
  import apf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Coding select
  input wire logic [7:0] pixel_format_code,
  // Sensor side
  input wire logic [7:0] sensor_pixel,
  input wire logic sensor_valid,
  // Output side
  output logic [7:0] pix_data,
  output logic pix_valid
);

  wire code_raw8 = (pixel_format_code == APF_CODE_MONO8);
  wire take = sensor_valid && code_raw8;

  // ****************************************************************
  // Raw output register
  // ****************************************************************
  // raw pass-through
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_data <= 8'h00;
      pix_valid <= 1'b0;
    end else if (ce) begin
      pix_valid <= take;
      if (take) begin
        pix_data <= sensor_pixel;
      end
    end
  end

  property p_raw_pass;
    @(posedge clk) disable iff (rst)
    (ce && take) |=> (pix_valid && pix_data == $past(sensor_pixel));
  endproperty
  a_raw_pass: assert property (p_raw_pass)
    else $error("raw pixel altered");

endmodule
`default_nettype wire

// [apf_host_model.sv]
// Purpose: Host-side model issuing quadlet requests
// Assumes: Answer strobe rises on the same clock edge that takes the request
// Notes: Idle request lines carry inverted data to expose stale use
`timescale 1ns/1ns
`default_nettype none

module apf_host_model (
  // Clock
  input wire logic clk,
  // Request
  output logic req_valid,
  output logic req_write,
  output logic [47:0] req_addr,
  output logic [31:0] req_wdata,
  // Answer
  input wire logic resp_valid,
  input wire logic resp_err,
  input wire logic [31:0] resp_rdata
);
  // ****************************************
  // Quadlet transfer
  // ****************************************
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 48'h0;
    req_wdata = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [47:0] addr,
    input logic [31:0] wd, output logic [31:0] rd, output logic er,
    output logic ok);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = addr;
    req_wdata = wd;
    @(negedge clk);
    req_valid = 1'b0;
    req_write = ~wr;
    req_addr = ~addr;
    req_wdata = ~wd;
    ok = resp_valid;
    er = resp_err;
    rd = resp_rdata;
  endtask
endmodule

`default_nettype wire

// [tb_aoi_pixel_format_regs.sv]
// Purpose: Self-checking bench for the custom-format register bank
// Assumes: Inputs driven on the falling clock edge
// Notes: Host requests go through the host model tasks
`timescale 1ns/1ns
`default_nettype none

module tb_aoi_pixel_format_regs;
  import apf_pkg::*;
  localparam logic [47:0] BASE = 48'hffff_f1f0_0100;
  logic clk, rst, ce, req_valid, req_write, resp_valid, resp_err;
  logic sensor_valid, pix_valid, er, ok;
  logic [47:0] req_addr;
  logic [31:0] req_wdata, resp_rdata, rd;
  logic [15:0] aoi_left, aoi_top, aoi_width, aoi_height;
  logic [7:0] pixel_format_code, sensor_pixel, pix_data;
  logic [47:0] inq_ofs [3] = '{48'h000, 48'h004, 48'h014};
  logic [31:0] inq_val [3] = '{32'h056c_040e, 32'h0002_0002, 32'h8000_0000};
  int n_mismatch, n_checks;

  // ****************************************
  // Clock, design and host
  // ****************************************
  initial clk = 1'b0;
  always #50 clk = ~clk;

  apf_regs dut (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_err(resp_err), .resp_rdata(resp_rdata),
    .aoi_left(aoi_left), .aoi_top(aoi_top), .aoi_width(aoi_width),
    .aoi_height(aoi_height), .pixel_format_code(pixel_format_code),
    .sensor_pixel(sensor_pixel), .sensor_valid(sensor_valid),
    .pix_data(pix_data), .pix_valid(pix_valid));

  apf_host_model host (.clk(clk), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_err(resp_err), .resp_rdata(resp_rdata));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run();
    if (n_checks > 0 && n_mismatch == 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdq(input logic [47:0] a, input logic [31:0] exp,
    input logic exp_er);
    host.xfer(1'b0, a, 32'h0, rd, er, ok);
    chk({31'h0, ok}, 32'h1);
    chk({31'h0, er}, {31'h0, exp_er});
    chk(rd, exp);
  endtask

  task automatic wrq(input logic [47:0] a, input logic [31:0] wd);
    host.xfer(1'b1, a, wd, rd, er, ok);
    chk({30'h0, ok, er}, 32'h2);
    chk(rd, 32'h0);
  endtask

  task automatic pixels(input logic code_ok);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      if (i > 0 && code_ok) begin
        chk({23'h0, pix_valid, pix_data},
          {23'h0, 1'b1, 8'hc3 ^ 8'(i - 1)});
      end
      if (i > 0 && !code_ok) begin
        chk({31'h0, pix_valid}, 32'h0);
      end
      sensor_valid = (i < 3);
      sensor_pixel = (i < 3) ? 8'hc3 ^ 8'(i) : ~sensor_pixel;
    end
    @(negedge clk);
    chk({31'h0, pix_valid}, 32'h0);
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    sensor_valid = 1'b0;
    sensor_pixel = 8'h00;
    n_mismatch = 0;
    n_checks = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk({aoi_width, aoi_height}, 32'h056c_040e);
    rdq(BASE + 48'h008, 32'h0, 1'b0);
    rdq(BASE + 48'h00c, 32'h056c_040e, 1'b0);
    rdq(BASE + 48'h010, 32'h0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      rdq(BASE + inq_ofs[i], inq_val[i], 1'b0);
      wrq(BASE + inq_ofs[i], 32'hffff_ffff);
      rdq(BASE + inq_ofs[i], inq_val[i], 1'b0);
    end
    wrq(BASE + 48'h008, 32'h0012_0034);
    chk({aoi_left, aoi_top}, 32'h0012_0034);
    rdq(BASE + 48'h008, 32'h0012_0034, 1'b0);
    wrq(BASE + 48'h00c, 32'h0100_0080);
    chk({aoi_width, aoi_height}, 32'h0100_0080);
    rdq(BASE + 48'h00c, 32'h0100_0080, 1'b0);
    wrq(BASE + 48'h010, 32'h00ff_ffff);
    rdq(BASE + 48'h010, 32'h0, 1'b0);
    chk({24'h0, pixel_format_code}, 32'h0);
    pixels(1'b1);
    // Unsupported coding written on purpose: output must stay silent
    wrq(BASE + 48'h010, 32'h0900_0000);
    chk({24'h0, pixel_format_code}, 32'h9);
    pixels(1'b0);
    wrq(BASE + 48'h010, 32'h0);
    rdq(BASE + 48'h018, 32'h0, 1'b1);
    rdq(BASE + 48'h002, 32'h0, 1'b1);
    rdq(48'hffff_f1f0_0000, 32'h0, 1'b1);
    // Let the last answer strobe fall before freezing the block
    @(negedge clk);
    ce = 1'b0;
    host.xfer(1'b1, BASE + 48'h008, 32'h0, rd, er, ok);
    chk({31'h0, ok}, 32'h0);
    chk({aoi_left, aoi_top}, 32'h0012_0034);
    ce = 1'b1;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rdq(BASE + 48'h008, 32'h0, 1'b0);
    rdq(BASE + 48'h00c, 32'h056c_040e, 1'b0);
    complete_run();
  end
endmodule

`default_nettype wire
